/* File: rtl/psr_pkg.sv */
// Constants shared by the dual pressure setpoint relay block
`default_nettype none

package psr_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned NUM_CH = 2;
   localparam int unsigned HYST_W = 8;
   localparam int unsigned EV_W   = 2 * NUM_CH;

   // Register byte offsets, channel registers repeat every stride
   localparam logic [7:0] OFF_TRIP0  = 8'h00;
   localparam logic [7:0] OFF_CFG0   = 8'h04;
   localparam logic [7:0] OFF_STRIDE = 8'h08;
   localparam logic [7:0] OFF_STATE  = 8'h10;
   localparam logic [7:0] OFF_IRQ_ST = 8'h14;
   localparam logic [7:0] OFF_IRQ_MK = 8'h18;
   localparam logic [7:0] OFF_PRESS  = 8'h1C;

   // Configuration word fields
   localparam int unsigned CFG_POL_BIT  = 0;
   localparam int unsigned CFG_EN_BIT   = 1;
   localparam int unsigned CFG_HYST_LSB = 8;

   // Pressure is linear in millionths of the selected unit
   localparam logic [31:0] TRIP_MIN = 32'h0000_0064;
   localparam logic [31:0] TRIP_MAX = 32'h05F5_E100;
   localparam logic [31:0] TRIP_RST = TRIP_MIN;

   localparam logic [HYST_W-1:0] HYST_RST = 8'h0A;
   localparam logic [HYST_W-1:0] HYST_MAX = 8'h63;
   localparam logic [39:0]       PCT_DIV  = 40'h00_0000_0064;

   localparam logic POL_RST = 1'b0;
   localparam logic EN_RST  = 1'b1;

   localparam logic [EV_W-1:0] MASK_RST = 4'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : psr_pkg

`default_nettype wire

/* File: rtl/psr_top.sv */
// Dual pressure setpoint comparators with relay drives and AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none

module psr_top (
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rstn,
   input  wire logic [psr_pkg::DATA_W-1:0]  i_pressure,
   output logic      [psr_pkg::NUM_CH-1:0]  o_relay,
   output logic                             o_irq,
   input  wire logic [psr_pkg::ADDR_W-1:0]  i_awaddr,
   input  wire logic                        i_awvalid,
   output logic                             o_awready,
   input  wire logic [psr_pkg::DATA_W-1:0]  i_wdata,
   input  wire logic [3:0]                  i_wstrb,
   input  wire logic                        i_wvalid,
   output logic                             o_wready,
   output logic      [1:0]                  o_bresp,
   output logic                             o_bvalid,
   input  wire logic                        i_bready,
   input  wire logic [psr_pkg::ADDR_W-1:0]  i_araddr,
   input  wire logic                        i_arvalid,
   output logic                             o_arready,
   output logic      [psr_pkg::DATA_W-1:0]  o_rdata,
   output logic      [1:0]                  o_rresp,
   output logic                             o_rvalid,
   input  wire logic                        i_rready
);

   localparam int unsigned NCH = psr_pkg::NUM_CH;
   localparam int unsigned HW  = psr_pkg::HYST_W;
   localparam int unsigned EVW = psr_pkg::EV_W;

   // Byte lanes merged into an old word
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0]  strb
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = data[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [31:0] clamp_trip(input logic [31:0] v);
      logic [31:0] r;
      r = v;
      if (v < psr_pkg::TRIP_MIN) begin
         r = psr_pkg::TRIP_MIN;
      end else if (v > psr_pkg::TRIP_MAX) begin
         r = psr_pkg::TRIP_MAX;
      end
      return r;
   endfunction : clamp_trip

   // Percent of the trip point; fits 32 bits since trip and percent are capped
   function automatic logic [31:0] hyst_offset(
      input logic [31:0]   trip,
      input logic [HW-1:0] pct
   );
      logic [39:0] prod;
      logic [39:0] quot;
      prod = {8'h00, trip} * {32'h0000_0000, pct};
      quot = prod / psr_pkg::PCT_DIV;
      return quot[31:0];
   endfunction : hyst_offset

   function automatic logic [31:0] cfg_word(
      input logic          pol,
      input logic          en,
      input logic [HW-1:0] pct
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      r[psr_pkg::CFG_POL_BIT] = pol;
      r[psr_pkg::CFG_EN_BIT] = en;
      r[psr_pkg::CFG_HYST_LSB +: HW] = pct;
      return r;
   endfunction : cfg_word

   // Channel settings
   logic [NCH-1:0][31:0]   trip;
   logic [NCH-1:0][HW-1:0] hyst;
   logic [NCH-1:0]         pol_rev;
   logic [NCH-1:0]         rly_en;

   logic [EVW-1:0] irq_st;
   logic [EVW-1:0] irq_mask;

   // Write channel holding state
   logic        aw_full;
   logic        w_full;
   logic [7:0]  waddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;

   wire logic aw_hs   = i_awvalid & o_awready;
   wire logic w_hs    = i_wvalid & o_wready;
   wire logic b_hs    = o_bvalid & i_bready;
   wire logic ar_hs   = i_arvalid & o_arready;
   wire logic r_hs    = o_rvalid & i_rready;
   wire logic wr_fire = aw_full & w_full & ~o_bvalid;

   // Low address bits ignored, word access only
   wire logic [7:0]  wr_addr = {waddr[7:2], 2'b00};
   wire logic [7:0]  rd_addr = {i_araddr[7:2], 2'b00};
   wire logic [31:0] wr_bits = merge(32'h0000_0000, wdata, wstrb);

   wire logic st_we = wr_fire & (wr_addr == psr_pkg::OFF_IRQ_ST);
   wire logic mk_we = wr_fire & (wr_addr == psr_pkg::OFF_IRQ_MK);

   logic [NCH-1:0]         trip_we;
   logic [NCH-1:0]         cfg_we;
   logic [NCH-1:0]         trip_hit;
   logic [NCH-1:0]         cfg_hit;
   logic [NCH-1:0][31:0]   next_trip;
   logic [NCH-1:0][HW-1:0] next_hyst;
   logic [NCH-1:0]         next_pol;
   logic [NCH-1:0]         next_en;
   logic [NCH-1:0]         next_relay;
   logic [EVW-1:0]         ev;
   logic [NCH-1:0][31:0]   rd_trip;
   logic [NCH-1:0][31:0]   rd_cfg;
   logic [NCH-1:0]         rd_trip_hit;
   logic [NCH-1:0]         rd_cfg_hit;

   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      localparam logic [7:0] A_TRIP =
         8'(psr_pkg::OFF_TRIP0 + psr_pkg::OFF_STRIDE * ch);
      localparam logic [7:0] A_CFG =
         8'(psr_pkg::OFF_CFG0 + psr_pkg::OFF_STRIDE * ch);

      logic [31:0]   off;
      logic [31:0]   rel_hi;
      logic [31:0]   rel_lo;
      logic          act;
      logic          rel;
      logic [31:0]   cfg_new;
      logic [HW-1:0] pct_new;

      assign trip_hit[ch] = (wr_addr == A_TRIP);
      assign cfg_hit[ch]  = (wr_addr == A_CFG);
      assign trip_we[ch]  = wr_fire & trip_hit[ch];
      assign cfg_we[ch]   = wr_fire & cfg_hit[ch];

      assign next_trip[ch] = clamp_trip(merge(trip[ch], wdata, wstrb));

      assign cfg_new = merge(cfg_word(pol_rev[ch], rly_en[ch], hyst[ch]), wdata, wstrb);
      assign pct_new = cfg_new[psr_pkg::CFG_HYST_LSB +: HW];

      assign next_hyst[ch] = (pct_new > psr_pkg::HYST_MAX) ? psr_pkg::HYST_MAX : pct_new;
      assign next_pol[ch] = cfg_new[psr_pkg::CFG_POL_BIT];
      assign next_en[ch] = cfg_new[psr_pkg::CFG_EN_BIT];

      assign off    = hyst_offset(trip[ch], hyst[ch]);
      assign rel_hi = trip[ch] + off;
      assign rel_lo = trip[ch] - off;

      assign act = pol_rev[ch] ? (i_pressure > trip[ch]) : (i_pressure < trip[ch]);
      assign rel = pol_rev[ch] ? (i_pressure <= rel_lo) : (i_pressure >= rel_hi);

      // Hold inside band, off when disabled
      assign next_relay[ch] = ~rly_en[ch] ? 1'b0 :
                              act         ? 1'b1 :
                              rel         ? 1'b0 : o_relay[ch];

      assign ev[2*ch]   = next_relay[ch] & ~o_relay[ch];
      assign ev[2*ch+1] = ~next_relay[ch] & o_relay[ch];

      assign rd_trip_hit[ch] = (rd_addr == A_TRIP);
      assign rd_cfg_hit[ch]  = (rd_addr == A_CFG);
      assign rd_trip[ch] = rd_trip_hit[ch] ? trip[ch] : 32'h0000_0000;
      assign rd_cfg[ch]  = rd_cfg_hit[ch] ?
                           cfg_word(pol_rev[ch], rly_en[ch], hyst[ch]) : 32'h0000_0000;
   end

   wire logic wr_ok = (|trip_hit) | (|cfg_hit) |
                      (wr_addr == psr_pkg::OFF_IRQ_ST) |
                      (wr_addr == psr_pkg::OFF_IRQ_MK);

   // Raised events win over a clear landing in the same cycle
   wire logic [EVW-1:0] clr_bits     = st_we ? wr_bits[EVW-1:0] : {EVW{1'b0}};
   wire logic [EVW-1:0] next_irq_st  = (irq_st & ~clr_bits) | ev;
   // Mask honours byte lanes like every other register
   wire logic [31:0]    mk_merged    = merge({{(32-EVW){1'b0}}, irq_mask}, wdata, wstrb);
   wire logic [EVW-1:0] next_irq_mk  = mk_we ? mk_merged[EVW-1:0] : irq_mask;

   // Read selection
   wire logic rd_state = (rd_addr == psr_pkg::OFF_STATE);
   wire logic rd_ist   = (rd_addr == psr_pkg::OFF_IRQ_ST);
   wire logic rd_imk   = (rd_addr == psr_pkg::OFF_IRQ_MK);
   wire logic rd_prs   = (rd_addr == psr_pkg::OFF_PRESS);

   wire logic rd_ok = (|rd_trip_hit) | (|rd_cfg_hit) |
                      rd_state | rd_ist | rd_imk | rd_prs;

   logic [31:0] rd_chan;

   always_comb begin
      rd_chan = 32'h0000_0000;
      for (int c = 0; c < NCH; c++) begin
         rd_chan = rd_chan | rd_trip[c] | rd_cfg[c];
      end
   end

   wire logic [31:0] rd_data =
      rd_state ? {{(32-NCH){1'b0}}, o_relay} :
      rd_ist   ? {{(32-EVW){1'b0}}, irq_st} :
      rd_imk   ? {{(32-EVW){1'b0}}, irq_mask} :
      rd_prs   ? i_pressure : rd_chan;

   // Channel settings and relay drives
   always_ff @(posedge i_ref_clk) begin
      for (int c = 0; c < NCH; c++) begin
         if (!i_rstn) begin
            trip[c] <= psr_pkg::TRIP_RST;
            hyst[c] <= psr_pkg::HYST_RST;
            pol_rev[c] <= psr_pkg::POL_RST;
            rly_en[c] <= psr_pkg::EN_RST;
            o_relay[c] <= 1'b0;
         end else begin
            if (trip_we[c]) begin
               trip[c] <= next_trip[c];
            end
            if (cfg_we[c]) begin
               hyst[c] <= next_hyst[c];
               pol_rev[c] <= next_pol[c];
               rly_en[c] <= next_en[c];
            end
            o_relay[c] <= next_relay[c];
         end
      end
   end

   // Sticky events and masked interrupt level
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         irq_st <= {EVW{1'b0}};
         irq_mask <= psr_pkg::MASK_RST;
         o_irq <= 1'b0;
      end else begin
         irq_st <= next_irq_st;
         irq_mask <= next_irq_mk;
         o_irq <= |(next_irq_st & next_irq_mk);
      end
   end

   // Write address and data are taken in either order, one write at a time
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= psr_pkg::RESP_OKAY;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         waddr <= 8'h00;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_full <= 1'b1;
            o_awready <= 1'b0;
            waddr <= i_awaddr;
         end
         if (w_hs) begin
            w_full <= 1'b1;
            o_wready <= 1'b0;
            wdata <= i_wdata;
            wstrb <= i_wstrb;
         end
         // Settings land at the same edge the response rises
         if (wr_fire) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
         end
         if (b_hs) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   // Read data captured at address acceptance
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= psr_pkg::RESP_OKAY;
      end else begin
         // Refused reads answer with zero data
         if (ar_hs) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_ok ? rd_data : 32'h0000_0000;
            o_rresp <= rd_ok ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
         end
         if (r_hs) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

endmodule : psr_top

`default_nettype wire

/* File: verif/psr_checker.sv */
// Port-level assertions for the dual setpoint relay block
`default_nettype none

module psr_checker (
   input wire logic                       i_ref_clk,
   input wire logic                       i_rstn,
   input wire logic [psr_pkg::DATA_W-1:0] i_pressure,
   input wire logic [psr_pkg::NUM_CH-1:0] o_relay,
   input wire logic                       o_irq,
   input wire logic                       i_awvalid,
   input wire logic                       o_awready,
   input wire logic                       o_wready,
   input wire logic [1:0]                 o_bresp,
   input wire logic                       o_bvalid,
   input wire logic                       i_bready,
   input wire logic                       i_arvalid,
   input wire logic                       o_arready,
   input wire logic [psr_pkg::DATA_W-1:0] o_rdata,
   input wire logic [1:0]                 o_rresp,
   input wire logic                       o_rvalid,
   input wire logic                       i_rready
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   aw_drop_a: assert property (i_awvalid && o_awready |=> !o_awready)
      else $error("awready stayed high after address taken");
   ar_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read answer missing one cycle after address");
   b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before bready");
   r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before rready");
   b_after_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write response while a channel is ready");
   err_zero_a: assert property (o_rvalid && o_rresp == psr_pkg::RESP_SLVERR |-> o_rdata == '0)
      else $error("refused read returned data");
   // Pressure or settings must have moved one cycle earlier
   relay_hold_a: assert property ($changed(o_relay) && $past(i_rstn, 3) |->
      $past(i_pressure) != $past(i_pressure, 2) || $past(o_bvalid) && !$past(o_bvalid, 2))
      else $error("relay changed with steady inputs");
   irq_cause_a: assert property ($rose(o_irq) |-> $changed(o_relay) || $rose(o_bvalid))
      else $error("interrupt rose without relay event or write");

   cover property ($rose(o_relay[0]));
   cover property ($rose(o_irq));
   cover property (o_bvalid && o_bresp == psr_pkg::RESP_SLVERR);

endmodule : psr_checker

bind psr_top psr_checker u_chk (.i_ref_clk, .i_rstn, .i_pressure, .o_relay, .o_irq, .i_awvalid,
   .o_awready, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata,
   .o_rresp, .o_rvalid, .i_rready);

`default_nettype wire

/* File: verif/psr_relay_load.sv */
// Relay load model counting contact closures on both channels
`default_nettype none

module psr_relay_load (
   input  wire logic                       i_ref_clk,
   input  wire logic [psr_pkg::NUM_CH-1:0] i_relay,
   output var  int unsigned                o_closures
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [psr_pkg::NUM_CH-1:0] last = '0;
   initial o_closures = 0;
   always @(posedge i_ref_clk) begin
      o_closures <= o_closures + $countones(i_relay & ~last);
      last       <= i_relay;
   end
endmodule : psr_relay_load

`default_nettype wire

/* File: verif/psr_top_tb_top.sv */
// Self-checking bench for the dual setpoint relay block
`default_nettype none

module psr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] OK = psr_pkg::RESP_OKAY;
   localparam logic [1:0] ER = psr_pkg::RESP_SLVERR;
   logic        i_ref_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic [31:0] i_pressure = 32'h0000_00C8;
   logic [7:0]  i_awaddr = '0, i_araddr = '0;
   logic [31:0] i_wdata = '0, o_rdata;
   logic [3:0]  i_wstrb = 4'hF;
   logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic [1:0]  o_relay, o_bresp, o_rresp;
   logic        o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   int unsigned closures;
   int          n_errors = 0, total_checks = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   psr_top dut (.i_ref_clk, .i_rstn, .i_pressure, .o_relay, .o_irq, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
   psr_relay_load load (.i_ref_clk, .i_relay(o_relay), .o_closures(closures));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 64) begin
         n_errors++;
         $display("BAD %0t bus answer missing", $time);
         tally_and_finish();
      end
   endtask : tmo

   // Address and data offered together; bready raised late so the response must stand
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic ha, hw, hb, lb;
      @(posedge i_ref_clk);
      i_awaddr  <= a;
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      hb = 1'b0;
      for (n = 0; n < 64 && !hb; n++) begin
         @(negedge i_ref_clk);
         ha = i_awvalid & o_awready;
         hw = i_wvalid & o_wready;
         hb = i_bready & o_bvalid;
         lb = o_bvalid & ~i_bready;
         if (hb) chk(32'(o_bresp), 32'(er));
         @(posedge i_ref_clk);
         if (ha) i_awvalid <= 1'b0;
         if (hw) i_wvalid <= 1'b0;
         if (lb) i_bready <= 1'b1;
      end
      i_bready <= 1'b0;
      tmo(n);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int   n;
      logic ha, hr, lr;
      @(posedge i_ref_clk);
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      hr = 1'b0;
      for (n = 0; n < 64 && !hr; n++) begin
         @(negedge i_ref_clk);
         ha = i_arvalid & o_arready;
         hr = i_rready & o_rvalid;
         lr = o_rvalid & ~i_rready;
         if (hr) chk(o_rdata, ed);
         if (hr) chk(32'(o_rresp), 32'(er));
         @(posedge i_ref_clk);
         if (ha) i_arvalid <= 1'b0;
         if (lr) i_rready <= 1'b1;
      end
      i_rready <= 1'b0;
      tmo(n);
   endtask : rd

   // Relay settles within two edges of a pressure or setting change
   task automatic rly(input logic [1:0] exp);
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk(32'(o_relay), 32'(exp));
   endtask : rly

   task automatic press(input logic [31:0] p, input logic [1:0] exp);
      @(posedge i_ref_clk);
      i_pressure <= p;
      rly(exp);
   endtask : press

   task automatic irq(input logic exp);
      @(negedge i_ref_clk);
      chk(32'(o_irq), 32'(exp));
   endtask : irq

   task automatic t_defaults;
      logic [31:0] cfg;
      cfg = {16'h0000, psr_pkg::HYST_RST, 6'h00, psr_pkg::EN_RST, psr_pkg::POL_RST};
      rd(8'h00, psr_pkg::TRIP_RST, OK);
      rd(8'h04, cfg, OK);
      rd(8'h08, psr_pkg::TRIP_RST, OK);
      rd(8'h0C, cfg, OK);
      rd(8'h20, 32'h0000_0000, ER);
      wr(8'h10, 32'h0000_0001, ER);
   endtask : t_defaults

   task automatic t_normal;
      press(32'h0000_0063, 2'b11);
      press(32'h0000_0064, 2'b11);
      press(32'h0000_006D, 2'b11);
      press(32'h0000_006E, 2'b00);
   endtask : t_normal

   task automatic t_limits;
      wr(8'h00, 32'h0000_0000, OK);
      rd(8'h00, psr_pkg::TRIP_MIN, OK);
      wr(8'h00, 32'hFFFF_FFFF, OK);
      rd(8'h00, psr_pkg::TRIP_MAX, OK);
      rly(2'b01);
      wr(8'h00, 32'h0000_0064, OK);
      rly(2'b00);
   endtask : t_limits

   task automatic t_reverse;
      wr(8'h0C, 32'h0000_1403, OK);
      rly(2'b10);
      wr(8'h08, 32'h0000_03E8, OK);
      rly(2'b00);
      press(32'h0000_03E9, 2'b10);
      press(32'h0000_0321, 2'b10);
      press(32'h0000_0320, 2'b00);
      wr(8'h0C, 32'h0000_C803, OK);
      rd(8'h0C, 32'h0000_6303, OK);
   endtask : t_reverse

   task automatic t_disable;
      wr(8'h04, 32'h0000_0A00, OK);
      press(32'h0000_0032, 2'b00);
      rd(8'h1C, 32'h0000_0032, OK);
      @(posedge i_ref_clk);
      i_wstrb <= 4'h2;
      wr(8'h00, 32'hFFFF_01FF, OK);
      rd(8'h00, 32'h0000_0164, OK);
      i_wstrb <= 4'hF;
   endtask : t_disable

   task automatic t_irq;
      wr(8'h14, 32'h0000_000F, OK);
      wr(8'h18, 32'h0000_0001, OK);
      irq(1'b0);
      wr(8'h04, 32'h0000_0A02, OK);
      rly(2'b01);
      irq(1'b1);
      rd(8'h14, 32'h0000_0001, OK);
      rd(8'h10, 32'h0000_0001, OK);
      wr(8'h18, 32'h0000_0000, OK);
      irq(1'b0);
      wr(8'h18, 32'h0000_0001, OK);
      irq(1'b1);
      wr(8'h14, 32'h0000_0001, OK);
      irq(1'b0);
      chk(closures, 32'd6);
   endtask : t_irq

   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      t_defaults();
      t_normal();
      t_limits();
      t_reverse();
      t_disable();
      t_irq();
      tally_and_finish();
   end
endmodule : psr_top_tb_top

`default_nettype wire
